//--- pkg/panel_params.svh
/*
  timing counts, segment patterns and selector codes for the self-test panel.
  assumes a 10 MHz system clock.
*/
`ifndef PANEL_PARAMS_SVH
`define PANEL_PARAMS_SVH
`define CLK_HZ            10000000
`define LAMP_CHECK_MS     1000
`define LAMP_CHECK_CYC    ((`CLK_HZ / 1000) * `LAMP_CHECK_MS)
`define FLASH_HALF_MS     500
`define FLASH_HALF_CYC    ((`CLK_HZ / 1000) * `FLASH_HALF_MS)
`define ALLSEG_MS         500
`define ALLSEG_CYC        ((`CLK_HZ / 1000) * `ALLSEG_MS)
`define SEG_BLANK         8'h00
`define SEG_ALL           8'hff
`define SEG_LET_P         8'hf3
`define SEG_LET_F         8'hf1
`define SEG_LET_R         8'hd0
`define SEG_LET_D         8'hde
`define DP_BIT            7
`define UNIT_DRIVE        2'h0
`define UNIT_HOSTCTL      2'h2
`define TEST_FULL         1'b1
`define TEST_REDUCED      1'b0
`endif

//--- pkg/panel_pkg.sv
/*
  types for the self-test panel controller.
  assumes panel_params.svh is included by the design files.
*/
package panel_pkg;
  typedef struct packed {
    logic red;
    logic green;
  } lamp_t;
  typedef struct packed {
    logic [7:0] left;
    logic [7:0] right;
  } display_t;
  typedef struct packed {
    logic       start;
    logic       full;
  } test_req_t;
  typedef struct packed {
    logic       done;
    logic       pass;
    logic       hostctl_fail;
    logic       housekeeping;
  } test_stat_t;
endpackage

//--- hdl/hex_seg.sv
/*
  hex digit to seven segment pattern with decimal point (bit 7, segments g..a in 6:0).
  assumes a registered consumer; pure combinational.
*/
`include "panel_params.svh"
module hex_seg (
  input  wire logic [3:0] digit,
  input  wire logic       dp,
  output      logic [7:0] seg
);
  // ****************************************
  // digit decode
  // ****************************************
  // segment lookup table, active high
  always_comb
  begin
    case (digit)
      4'h0: seg = 8'h3f;
      4'h1: seg = 8'h06;
      4'h2: seg = 8'h5b;
      4'h3: seg = 8'h4f;
      4'h4: seg = 8'h66;
      4'h5: seg = 8'h6d;
      4'h6: seg = 8'h7d;
      4'h7: seg = 8'h07;
      4'h8: seg = 8'h7f;
      4'h9: seg = 8'h6f;
      4'ha: seg = 8'h77;
      4'hb: seg = 8'h7c;
      4'hc: seg = 8'h39;
      4'hd: seg = 8'h5e;
      4'he: seg = 8'h79;
      default: seg = 8'h71;
    endcase
    seg[`DP_BIT] = dp;
  end
endmodule

//--- hdl/self_test_panel_controller.sv
/*
  front lamp and rear display sequencer for drive self-test, with pushbutton release handshake.
  assumes test engine status from the same clock; pushbutton from a pin (synchronised here).
*/
// What this block does
// RL1: both lamps on one second at power-up
// RL2: flash green, red off during test
// RL3: pass shows steady green, red off
// RL4: fail: red on, green flashes during housekeeping, then off
// RL5: failed state: flash green on host command
// RL6: host controller fail: red and green steady
// RL7: passed: green steady idle, flashing active
// RL8: button or host test runs reduced set
// RL9: two seven-segment hex digits with points
// RL10: power-up or button: show 8.8 then blank
// RL11: host test to unit 0: blank immediately
// RL12: button requests release; grant blanks display
// RL13: start test only after button let go
// RL14: denied: show r.d. while held, then restore
// RL15: completion shows P.x. or F.x. with address
// RL16: flash half-period set by parameter, half second
`include "panel_params.svh"
module self_test_panel_controller #(
  parameter int unsigned LAMP_CHECK_CYC = `LAMP_CHECK_CYC,
  parameter int unsigned FLASH_HALF_CYC = `FLASH_HALF_CYC,
  parameter int unsigned ALLSEG_CYC     = `ALLSEG_CYC
) (
  input  wire logic                  CLK,
  input  wire logic                  NRST,
  input  wire logic                  BUTTON,
  input  wire logic                  HOST_TEST_CMD,
  input  wire logic [1:0]            HOST_TEST_UNIT,
  input  wire logic                  HOST_GRANT,
  input  wire logic                  HOST_DENY,
  input  wire logic                  ACTIVE,
  input  wire logic [3:0]            BUS_ADDR,
  input  wire panel_pkg::test_stat_t TEST_STAT,
  output      logic                  RELEASE_REQ,
  output      panel_pkg::test_req_t  TEST_REQ,
  output      panel_pkg::lamp_t      LAMP,
  output      panel_pkg::display_t   DISPLAY
);
  typedef enum logic [3:0] {
    S_LAMPCHK, S_ALLSEG, S_TESTING, S_HOUSEKEEP, S_IDLE, S_HOSTFAIL, S_REQREL, S_GRANTED, S_DENIED
  } state_t;

  // ****************************************
  // pushbutton synchroniser
  // ****************************************
  logic btn_meta_reg;
  logic btn_reg;
  // two stages; only btn_reg is read by logic
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      btn_meta_reg <= 1'b0;
      btn_reg      <= 1'b0;
    end
    else
    begin
      btn_meta_reg <= BUTTON;
      btn_reg      <= btn_meta_reg;
    end
  end

  // ****************************************
  // flash timebase
  // ****************************************
  logic [31:0] flash_cnt_reg;
  logic [31:0] flash_cnt_next;
  logic        flash_reg;
  logic        flash_next;
  // free-running square wave for green flashing
  always_comb
  begin
    flash_cnt_next = flash_cnt_reg + 32'h1;
    flash_next     = flash_reg;
    if (flash_cnt_reg >= FLASH_HALF_CYC - 1) // see RL16
    begin
      flash_cnt_next = 32'h0;
      flash_next     = ~flash_reg;
    end
  end
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      flash_cnt_reg <= 32'h0;
      flash_reg     <= 1'b0;
    end
    else
    begin
      flash_cnt_reg <= flash_cnt_next;
      flash_reg     <= flash_next;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  state_t      state_reg;
  state_t      state_next;
  logic [31:0] tmr_reg;
  logic [31:0] tmr_next;
  logic        passed_reg;
  logic        passed_next;
  logic        has_result_reg;
  logic        has_result_next;
  logic        show_all_reg;
  logic        show_all_next;
  logic        req_next;
  logic        start_next;
  logic        full_reg;
  logic        full_next;
  logic        start_reg;
  // state walk, test start and result memory
  always_comb
  begin
    state_next      = state_reg;
    tmr_next        = tmr_reg + 32'h1;
    passed_next     = passed_reg;
    has_result_next = has_result_reg;
    show_all_next   = show_all_reg;
    req_next        = 1'b0;
    start_next      = 1'b0;
    full_next       = full_reg;
    case (state_reg)
      S_LAMPCHK:
      begin
        if (tmr_reg >= LAMP_CHECK_CYC - 1) // see RL1
        begin
          state_next    = S_ALLSEG;
          tmr_next      = 32'h0;
          start_next    = 1'b1;
          full_next     = `TEST_FULL;
          show_all_next = 1'b1; // see RL10
        end
      end
      // a done pulse inside the 8.8 window is kept, not lost
      S_ALLSEG, S_TESTING:
      begin
        if (state_reg == S_ALLSEG && tmr_reg >= ALLSEG_CYC - 1)
        begin
          state_next    = S_TESTING;
          show_all_next = 1'b0; // see RL10
        end
        if (TEST_STAT.done)
        begin
          show_all_next   = 1'b0;
          has_result_next = 1'b1;
          passed_next     = TEST_STAT.pass;
          if (TEST_STAT.hostctl_fail)
            state_next = S_HOSTFAIL; // see RL6
          else if (!TEST_STAT.pass && TEST_STAT.housekeeping)
            state_next = S_HOUSEKEEP; // see RL4
          else
            state_next = S_IDLE;
        end
      end
      S_HOUSEKEEP:
      begin
        if (!TEST_STAT.housekeeping)
          state_next = S_IDLE; // see RL4
      end
      S_IDLE:
      begin
        if (HOST_TEST_CMD && HOST_TEST_UNIT == `UNIT_DRIVE)
        begin
          state_next    = S_TESTING; // see RL11
          start_next    = 1'b1;
          full_next     = `TEST_REDUCED; // see RL8
          show_all_next = 1'b0;
        end
        else if (btn_reg)
          state_next = S_REQREL; // see RL12
      end
      S_REQREL:
      begin
        req_next = 1'b1; // see RL12
        if (!btn_reg)
          state_next = S_IDLE;
        else if (HOST_GRANT)
          state_next = S_GRANTED;
        else if (HOST_DENY)
          state_next = S_DENIED; // see RL14
      end
      S_GRANTED:
      begin
        if (!btn_reg) // see RL13
        begin
          state_next    = S_ALLSEG;
          tmr_next      = 32'h0;
          start_next    = 1'b1;
          full_next     = `TEST_REDUCED; // see RL8
          show_all_next = 1'b1; // see RL10
        end
      end
      S_DENIED:
      begin
        if (!btn_reg)
          state_next = S_IDLE; // see RL14
      end
      default:
      begin
        state_next = S_HOSTFAIL; // host controller failure holds until power down
      end
    endcase
  end
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      state_reg      <= S_LAMPCHK;
      tmr_reg        <= 32'h0;
      passed_reg     <= 1'b0;
      has_result_reg <= 1'b0;
      show_all_reg   <= 1'b0;
      RELEASE_REQ    <= 1'b0;
      start_reg      <= 1'b0;
      full_reg       <= `TEST_FULL;
    end
    else
    begin
      state_reg      <= state_next;
      tmr_reg        <= tmr_next;
      passed_reg     <= passed_next;
      has_result_reg <= has_result_next;
      show_all_reg   <= show_all_next;
      RELEASE_REQ    <= req_next;
      start_reg      <= start_next;
      full_reg       <= full_next;
    end
  end
  assign TEST_REQ.start = start_reg;
  assign TEST_REQ.full  = full_reg;

  // ****************************************
  // lamp and display outputs
  // ****************************************
  logic [7:0]          addr_seg;
  panel_pkg::lamp_t    lamp_next;
  panel_pkg::display_t disp_next;
  hex_seg u_addr_seg (
    .digit (BUS_ADDR),
    .dp    (1'b1),
    .seg   (addr_seg)
  );
  // see RL9
  always_comb
  begin
    lamp_next = '{red: 1'b0, green: 1'b0};
    disp_next = '{left: `SEG_BLANK, right: `SEG_BLANK};
    case (state_reg)
      S_LAMPCHK:
        lamp_next = '{red: 1'b1, green: 1'b1}; // see RL1
      S_ALLSEG, S_TESTING:
        lamp_next = '{red: 1'b0, green: flash_reg}; // see RL2
      S_HOUSEKEEP:
        lamp_next = '{red: 1'b1, green: flash_reg}; // see RL4
      S_HOSTFAIL:
        lamp_next = '{red: 1'b1, green: 1'b1}; // see RL6
      default:
      begin
        if (passed_reg)
          lamp_next = '{red: 1'b0, green: ACTIVE ? flash_reg : 1'b1}; // see RL3 see RL7
        else
          lamp_next = '{red: 1'b1, green: ACTIVE & flash_reg}; // see RL5
      end
    endcase
    if (show_all_reg)
      disp_next = '{left: `SEG_ALL, right: `SEG_ALL}; // see RL10
    else if (state_reg == S_DENIED)
      disp_next = '{left: `SEG_LET_R, right: `SEG_LET_D}; // see RL14
    else if (state_reg == S_IDLE || state_reg == S_REQREL || state_reg == S_HOSTFAIL || state_reg == S_HOUSEKEEP)
    begin
      if (has_result_reg)
        disp_next = '{left: passed_reg ? `SEG_LET_P : `SEG_LET_F, right: addr_seg}; // see RL15
    end
  end
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      LAMP    <= '{red: 1'b0, green: 1'b0};
      DISPLAY <= '{left: `SEG_BLANK, right: `SEG_BLANK};
    end
    else
    begin
      LAMP    <= lamp_next;
      DISPLAY <= disp_next;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_lampchk;
    @(posedge CLK) disable iff (!NRST) (state_reg == S_LAMPCHK) |=> (LAMP.red && LAMP.green);
  endproperty
  a_lampchk: assert property (p_lampchk) else $error("lamp check not both lamps"); // see RL1
  property p_test_red_off;
    @(posedge CLK) disable iff (!NRST) (state_reg == S_TESTING) |=> !LAMP.red;
  endproperty
  a_test_red_off: assert property (p_test_red_off) else $error("red lit during test"); // see RL2
  property p_hostfail;
    @(posedge CLK) disable iff (!NRST) (state_reg == S_HOSTFAIL) |=> (LAMP.red && LAMP.green);
  endproperty
  a_hostfail: assert property (p_hostfail) else $error("host fail lamps wrong"); // see RL6
  property p_pass_idle;
    @(posedge CLK) disable iff (!NRST) (state_reg == S_IDLE && passed_reg && !ACTIVE) |=> (LAMP.green && !LAMP.red);
  endproperty
  a_pass_idle: assert property (p_pass_idle) else $error("pass idle not steady green"); // see RL3
  property p_fail_red;
    @(posedge CLK) disable iff (!NRST) (state_reg == S_IDLE && !passed_reg) |=> LAMP.red;
  endproperty
  a_fail_red: assert property (p_fail_red) else $error("fail state red off"); // see RL5
  property p_host_reduced;
    @(posedge CLK) disable iff (!NRST) (state_reg == S_IDLE && HOST_TEST_CMD && HOST_TEST_UNIT == `UNIT_DRIVE)
      |=> (TEST_REQ.start && !TEST_REQ.full) ##1 (DISPLAY.left == `SEG_BLANK);
  endproperty
  a_host_reduced: assert property (p_host_reduced) else $error("host test not reduced or not blank"); // see RL11
  property p_no_start_held;
    @(posedge CLK) disable iff (!NRST) (state_reg == S_GRANTED && btn_reg) |=> !TEST_REQ.start;
  endproperty
  a_no_start_held: assert property (p_no_start_held) else $error("test started while button held"); // see RL13
  property p_denied;
    @(posedge CLK) disable iff (!NRST) (state_reg == S_DENIED && !show_all_reg) |=> (DISPLAY.left == `SEG_LET_R);
  endproperty
  a_denied: assert property (p_denied) else $error("r.d. not shown"); // see RL14
  property p_reqrel;
    @(posedge CLK) disable iff (!NRST) (state_reg == S_REQREL) |=> RELEASE_REQ;
  endproperty
  a_reqrel: assert property (p_reqrel) else $error("release not requested"); // see RL12
endmodule

//--- verif/host_release_model.sv
/*
  host model on the far side of the release handshake.
  assumes the bench picks grant or deny and the answer delay.
*/
module host_release_model (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       req,
  input  wire logic       deny_sel,
  input  wire logic [1:0] delay,
  output      logic       grant,
  output      logic       deny
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_cnt;
  // answer a pending request after delay cycles, hold it until the request drops
  always @(negedge clk or negedge nrst)
    if (!nrst)
    begin
      wait_cnt <= 2'h0;
      grant    <= 1'b0;
      deny     <= 1'b0;
    end
    else if (!req)
    begin
      wait_cnt <= 2'h0;
      grant    <= 1'b0;
      deny     <= 1'b0;
    end
    else if (wait_cnt < delay)
      wait_cnt <= wait_cnt + 2'h1;
    else
    begin
      grant <= !deny_sel;
      deny  <= deny_sel;
    end
endmodule

//--- verif/tb_self_test_panel_controller.sv
/*
  self-checking bench for the self-test panel controller.
  assumes short timing parameters and a host model on the release lines.
*/
`include "panel_params.svh"
module tb_self_test_panel_controller;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LC = 20;
  localparam int FH = 4;
  localparam int AS = 10;
  localparam logic [6:0] HEX [16] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
                                      7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h39, 7'h5e, 7'h79, 7'h71};
  logic                  CLK;
  logic                  NRST;
  logic                  BUTTON;
  logic                  HOST_TEST_CMD;
  logic [1:0]            HOST_TEST_UNIT;
  logic                  HOST_GRANT;
  logic                  HOST_DENY;
  logic                  ACTIVE;
  logic [3:0]            BUS_ADDR;
  panel_pkg::test_stat_t TEST_STAT;
  logic                  RELEASE_REQ;
  panel_pkg::test_req_t  TEST_REQ;
  panel_pkg::lamp_t      LAMP;
  panel_pkg::display_t   DISPLAY;
  logic                  deny_sel;
  logic [1:0]            delay;
  logic [31:0]           rng;
  logic                  last_full;
  int                    errors;
  int                    tests_run;
  int                    starts;
  int                    s0;
  self_test_panel_controller #(
    .LAMP_CHECK_CYC (LC),
    .FLASH_HALF_CYC (FH),
    .ALLSEG_CYC     (AS)
  ) u_dut (
    .CLK            (CLK),
    .NRST           (NRST),
    .BUTTON         (BUTTON),
    .HOST_TEST_CMD  (HOST_TEST_CMD),
    .HOST_TEST_UNIT (HOST_TEST_UNIT),
    .HOST_GRANT     (HOST_GRANT),
    .HOST_DENY      (HOST_DENY),
    .ACTIVE         (ACTIVE),
    .BUS_ADDR       (BUS_ADDR),
    .TEST_STAT      (TEST_STAT),
    .RELEASE_REQ    (RELEASE_REQ),
    .TEST_REQ       (TEST_REQ),
    .LAMP           (LAMP),
    .DISPLAY        (DISPLAY)
  );
  host_release_model u_host (
    .clk      (CLK),
    .nrst     (NRST),
    .req      (RELEASE_REQ),
    .deny_sel (deny_sel),
    .delay    (delay),
    .grant    (HOST_GRANT),
    .deny     (HOST_DENY)
  );
  // ***************
  // helpers
  // ***************
  function automatic logic [31:0] xs(logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge CLK);
  endtask
  // watch lamps: mode 0 green off, 1 green steady, 2 green flashing
  task automatic lamps(logic red, int mode);
    int   tog;
    logic g0;
    tog = 0;
    g0 = LAMP.green;
    repeat (4 * FH)
    begin
      @(negedge CLK);
      chk("red lamp", red, LAMP.red);
      if (LAMP.green !== g0)
        tog++;
      g0 = LAMP.green;
      if (mode < 2)
        chk("green lamp", mode[0], LAMP.green);
    end
    if (mode == 2)
      chk("green flash", 16'h1, tog >= 2);
  endtask
  // bounded wait for one start pulse, then its routine set
  task automatic wait_start(logic full);
    int n;
    n = starts;
    for (int i = 0; i < 40 && starts == n; i++)
      @(negedge CLK);
    if (starts != n + 1)
    begin
      $display("[ERR] start pulse expected 1 seen 0");
      errors++;
      give_verdict();
    end
    else
      chk("routine set", full, last_full);
  endtask
  // test engine: flashing and blank while running, then a done pulse
  task automatic finish_test(logic pass, logic hc, logic hk);
    lamps(1'b0, 2);
    chk("blank while testing", 16'h0, DISPLAY);
    rng = xs(rng);
    cyc(2 + rng[3:0]);
    TEST_STAT = '{1'b1, pass, hc, hk};
    cyc(1);
    TEST_STAT.done = 1'b0;
    cyc(3);
  endtask
  task automatic result(logic [7:0] left);
    chk("result display", {left, 1'b1, HEX[BUS_ADDR]}, DISPLAY);
  endtask
  task automatic host_cmd(logic [1:0] unit);
    HOST_TEST_UNIT = unit;
    HOST_TEST_CMD = 1'b1;
    cyc(1);
    HOST_TEST_CMD = 1'b0;
  endtask
  // count start pulses and keep the last routine set
  always @(posedge CLK)
    if (TEST_REQ.start === 1'b1)
    begin
      starts++;
      last_full = TEST_REQ.full;
    end
  // free-running clock, 100 ns period
  initial
  begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  // main sequence, inputs change at the falling edge
  initial
  begin
    NRST = 1'b0;
    BUTTON = 1'b0;
    HOST_TEST_CMD = 1'b0;
    HOST_TEST_UNIT = 2'h0;
    ACTIVE = 1'b0;
    TEST_STAT = '0;
    deny_sel = 1'b0;
    errors = 0;
    tests_run = 0;
    starts = 0;
    rng = xs(32'h2b);
    BUS_ADDR = rng[3:0];
    delay = rng[5:4];
    repeat (12) @(negedge CLK);
    NRST = 1'b1;
    cyc(2);
    repeat (LC - 4)
    begin
      chk("lamp check", 16'h3, LAMP);
      cyc(1);
    end
    chk("early start", 16'h0, starts);
    wait_start(`TEST_FULL);
    cyc(1);
    chk("all segments", 16'hffff, DISPLAY);
    finish_test(1'b1, 1'b0, 1'b0);
    result(`SEG_LET_P);
    lamps(1'b0, 1);
    ACTIVE = 1'b1;
    lamps(1'b0, 2);
    ACTIVE = 1'b0;
    $display("test power-up pass ended");
    host_cmd(2'h1);
    cyc(5);
    result(`SEG_LET_P);
    host_cmd(2'h0);
    wait_start(`TEST_REDUCED);
    repeat (AS + 2)
    begin
      chk("host test blank", 16'h0, DISPLAY);
      cyc(1);
    end
    finish_test(1'b0, 1'b0, 1'b1);
    lamps(1'b1, 2);
    result(`SEG_LET_F);
    TEST_STAT.housekeeping = 1'b0;
    cyc(2);
    lamps(1'b1, 0);
    ACTIVE = 1'b1;
    lamps(1'b1, 2);
    ACTIVE = 1'b0;
    $display("test host fail ended");
    rng = xs(rng);
    delay = rng[1:0];
    deny_sel = 1'b1;
    s0 = starts;
    BUTTON = 1'b1;
    cyc(4);
    chk("release request", 16'h1, RELEASE_REQ);
    cyc(16);
    chk("denied message", {`SEG_LET_R, `SEG_LET_D}, DISPLAY);
    BUTTON = 1'b0;
    cyc(8);
    result(`SEG_LET_F);
    chk("denied start", 16'h1, starts == s0);
    $display("test release denied ended");
    deny_sel = 1'b0;
    BUTTON = 1'b1;
    cyc(20);
    chk("granted blank", 16'h0, DISPLAY);
    chk("held start", 16'h1, starts == s0);
    BUTTON = 1'b0;
    wait_start(`TEST_REDUCED);
    cyc(1);
    chk("button segments", 16'hffff, DISPLAY);
    finish_test(1'b1, 1'b0, 1'b0);
    result(`SEG_LET_P);
    $display("test release granted ended");
    host_cmd(2'h0);
    wait_start(`TEST_REDUCED);
    finish_test(1'b0, 1'b1, 1'b0);
    lamps(1'b1, 1);
    result(`SEG_LET_F);
    $display("test controller fail ended");
    give_verdict();
  end
endmodule
